/* logic/fsw_flags.sv */
// Status word flag logic of the floating-point unit.
`timescale 1ns/1ps
`include "fsw_map.svh"
// Function
// - Six sticky exception flags sit in status bits 0 to 5.
// - Summary bit 7 is set when any unmasked flag is set.
// - A masked exception sets its flag but not the summary.
// - A set summary bit raises the exception request to the core.
// - Clear and initialise instructions clear the exception flags.
// - Environment load and restore overwrite flags and codes from the image.
// - Bit 15 always copies the summary bit.
// - Classic compares encode result in codes 0, 2, 3; code 1 cleared.
// - Core-flag compares write zero, parity, carry; code 1 shows stack fault.
// - Arithmetic class sets code 1 on upward rounding unless a stack fault occurs.
// - Trig class sets code 2 when out of range, code 1 roundup.
// - Move class clears code 1 unless a stack fault occurs.
// - Initialise clears all four codes; listed others leave them.
// - Stack overflow or underflow sets stack fault bit 6.
// - An invalid operand without stack fault leaves bit 6 alone.
// - Under stack fault, code 1 is 1 for overflow, 0 for underflow.
// - Initialise and clear instructions clear the stack fault.
// - Store status moves the whole status word into the accumulator.
// - Flags-from-accumulator copies accumulator high byte to core flags.
// - Conditional moves are decided from zero, parity and carry flags.
// - Remainder sets code 2 if partial, else quotient bits into 0, 3, 1.
// - Examine puts sign in code 1 and operand class in the others.
module fsw_flags (
	input wire logic CLK_SYS_I,
	input wire logic SRST_I,
	input wire logic CE_I,
	input fsw_pkg::fsw_req_t REQ_I,
	input wire logic [5:0] CW_MASK_I,
	input wire logic [2:0] TOP_I,
	input wire logic [15:0] IMAGE_I,
	output logic [15:0] STATUS_O,
	output logic EXC_REQ_O,
	output logic [15:0] ACCUM_O,
	output logic [7:0] CORE_FLAGS_O,
	output logic CMOV_TAKE_O
);
	import fsw_pkg::*;

	logic [5:0] flags;
	logic sf;
	logic es;
	logic [3:0] cc;
	logic [2:0] top;
	logic [15:0] accum;
	logic [7:0] core_flags;
	logic cmov_take;
	logic [3:0] next_cc;

	function automatic logic [15:0] pack_word(input logic [5:0] f, input logic s,
		input logic e, input logic [3:0] c, input logic [2:0] t);
		logic [15:0] w;
		w = {10'h000, f};
		w[`FSW_B_SF] = s;
		w[`FSW_B_ES] = e;
		w[`FSW_B_C0] = c[0];
		w[`FSW_B_C1] = c[1];
		w[`FSW_B_C2] = c[2];
		w[`FSW_B_TOP +: 3] = t;
		w[`FSW_B_C3] = c[3];
		w[`FSW_B_BSY] = e;
		return w;
	endfunction : pack_word

	function automatic logic summary(input logic [5:0] f, input logic [5:0] m);
		return |(f & ~m);
	endfunction : summary

	// Select bit 2 inverts the sense; 0 below, 1 equal, 2 below-or-equal, 3 unordered.
	function automatic logic cmov_cond(input logic [2:0] sel, input logic [7:0] fl);
		logic c;
		c = 1'b0;
		unique case (sel[1:0])
			2'h0: c = fl[`FSW_B_CF];
			2'h1: c = fl[`FSW_B_ZF];
			2'h2: c = fl[`FSW_B_CF] | fl[`FSW_B_ZF];
			2'h3: c = fl[`FSW_B_PF];
		endcase
		return c ^ sel[2];
	endfunction : cmov_cond

	wire go = CE_I & REQ_I.valid;
	wire is_clr = (REQ_I.cls == CLS_CLEX) | (REQ_I.cls == CLS_INIT);
	wire clr = go & is_clr;
	wire ld_img = go & (REQ_I.cls == CLS_IMAGE);
	wire stk = go & REQ_I.stk_fault;
	wire [5:0] new_exc = go ? (REQ_I.exc | {5'h00, REQ_I.stk_fault}) : 6'h00;
	wire [5:0] kept = clr ? `FSW_RST_FLAGS : flags;
	// A clearing instruction raises no exception of its own, so set and clear never collide.
	wire [5:0] next_flags = ld_img ? IMAGE_I[5:0] : (kept | new_exc);
	wire next_sf = ld_img ? IMAGE_I[`FSW_B_SF] : ((clr ? 1'b0 : sf) | stk);
	wire next_es = summary(next_flags, CW_MASK_I);
	wire [15:0] word = pack_word(flags, sf, es, cc, top);
	wire unord = REQ_I.cmp_un;
	wire [7:0] cmpi_flags = {core_flags[7], REQ_I.cmp_eq | unord, core_flags[5:3],
		unord, core_flags[1], REQ_I.cmp_lt | unord};
	wire [7:0] next_core = (go & (REQ_I.cls == CLS_FLAGS_FROM_ACCUM_INSTR)) ? accum[15:8] :
		(go & (REQ_I.cls == CLS_CMPI)) ? cmpi_flags : core_flags;
	wire do_stsw = go & (REQ_I.cls == CLS_STSW);
	wire next_take = go & (REQ_I.cls == CLS_CMOV) & cmov_cond(REQ_I.cmov_sel, core_flags);

	// Classes whose codes are undefined keep the previous codes.
	always_comb
	begin
		next_cc = cc;
		if (go)
		begin
			unique case (REQ_I.cls)
				CLS_CMP: next_cc = {REQ_I.cmp_eq | unord, unord, 1'b0, REQ_I.cmp_lt | unord};
				CLS_CMPI: next_cc[1] = 1'b0;
				CLS_ARITH: next_cc[1] = REQ_I.roundup;
				CLS_TRIG:
				begin
					next_cc[2] = REQ_I.partial;
					next_cc[1] = REQ_I.roundup;
				end
				CLS_MOVE: next_cc[1] = 1'b0;
				CLS_EXAM: next_cc = {REQ_I.oper_class[2:1], REQ_I.sign, REQ_I.oper_class[0]};
				CLS_PREM: next_cc = REQ_I.partial ? {cc[3], 1'b1, cc[1:0]} :
					{REQ_I.quot[1], 1'b0, REQ_I.quot[0], REQ_I.quot[2]};
				CLS_IMAGE: next_cc = {IMAGE_I[`FSW_B_C3], IMAGE_I[`FSW_B_C2],
					IMAGE_I[`FSW_B_C1], IMAGE_I[`FSW_B_C0]};
				CLS_INIT: next_cc = `FSW_RST_CC;
				default: next_cc = cc;
			endcase
			// An image load restores every code bit, so a fault flag must not overwrite it.
			if (REQ_I.stk_fault & (REQ_I.cls != CLS_IMAGE))
				next_cc[1] = REQ_I.stk_over;
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			flags <= `FSW_RST_FLAGS;
			sf <= 1'b0;
			es <= 1'b0;
			cc <= `FSW_RST_CC;
			top <= 3'h0;
		end
		else if (CE_I)
		begin
			flags <= next_flags;
			sf <= next_sf;
			es <= next_es;
			cc <= next_cc;
			top <= TOP_I;
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			accum <= `FSW_RST_WORD;
			core_flags <= `FSW_RST_CORE;
			cmov_take <= 1'b0;
		end
		else if (CE_I)
		begin
			if (do_stsw)
				accum <= word;
			core_flags <= next_core;
			cmov_take <= next_take;
		end
	end

	assign STATUS_O = word;
	assign EXC_REQ_O = es;
	assign ACCUM_O = accum;
	assign CORE_FLAGS_O = core_flags;
	assign CMOV_TAKE_O = cmov_take;

	a_flags_sticky: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(CE_I & !clr & !ld_img) |=> ((STATUS_O[5:0] & $past(flags)) == $past(flags)))
		else $error("exception flag dropped without a clearing instruction");
	a_flag_sets: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & !ld_img & (REQ_I.exc != 6'h00)) |=> ((STATUS_O[5:0] & $past(REQ_I.exc))
		== $past(REQ_I.exc)))
		else $error("detected exception did not set its flag");
	a_summary_unmask: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		CE_I |=> (STATUS_O[`FSW_B_ES] == |($past(next_flags) & ~$past(CW_MASK_I))))
		else $error("summary bit disagrees with unmasked flags");
	a_masked_quiet: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(CE_I & ((next_flags & ~CW_MASK_I) == 6'h00)) |=> !STATUS_O[`FSW_B_ES])
		else $error("masked exception set the summary bit");
	a_request_follows: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		$past(CE_I) |-> (EXC_REQ_O == |(STATUS_O[5:0] & ~$past(CW_MASK_I))))
		else $error("exception request does not follow unmasked flags");
	a_legacy_copy: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		STATUS_O[`FSW_B_BSY] == STATUS_O[`FSW_B_ES])
		else $error("bit 15 differs from summary bit");
	a_clear_flags: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(clr & (REQ_I.exc == 6'h00) & !REQ_I.stk_fault) |=> (STATUS_O[6:0] == 7'h00))
		else $error("clearing instruction left a flag set");
	a_image_load: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		ld_img |=> (STATUS_O[5:0] == $past(IMAGE_I[5:0])) &&
		(STATUS_O[`FSW_B_C3] == $past(IMAGE_I[`FSW_B_C3])))
		else $error("image load did not overwrite flags and codes");
	a_compare_codes: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_CMP) & REQ_I.cmp_un & !REQ_I.stk_fault) |=>
		(STATUS_O[`FSW_B_C0] & STATUS_O[`FSW_B_C2] & STATUS_O[`FSW_B_C3] &
		!STATUS_O[`FSW_B_C1]))
		else $error("unordered compare codes wrong");
	a_core_compare: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_CMPI) & REQ_I.cmp_lt & !REQ_I.cmp_un) |=>
		CORE_FLAGS_O[`FSW_B_CF] && !CORE_FLAGS_O[`FSW_B_PF])
		else $error("core-flag compare wrote wrong carry or parity");
	a_init_codes: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_INIT)) |=> (STATUS_O[10:8] == 3'h0) && !STATUS_O[14])
		else $error("initialise left a condition code set");
	a_stack_set: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(stk & !ld_img) |=> STATUS_O[`FSW_B_SF] && STATUS_O[0])
		else $error("stack fault did not set its flag");
	a_fault_c1: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(stk & !ld_img & (REQ_I.cls != CLS_INIT)) |=>
		(STATUS_O[`FSW_B_C1] == $past(REQ_I.stk_over)))
		else $error("code 1 does not show overflow or underflow");
	a_sf_sticky: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(CE_I & sf & !clr & !ld_img) |=> STATUS_O[`FSW_B_SF])
		else $error("stack fault flag dropped");
	a_store_accum: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		do_stsw |=> (ACCUM_O == $past(STATUS_O)))
		else $error("accumulator does not hold the status word");
	a_flags_accum: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(do_stsw ##1 (go & (REQ_I.cls == CLS_FLAGS_FROM_ACCUM_INSTR))) |=> (CORE_FLAGS_O == $past(STATUS_O[15:8], 2)))
		else $error("core flags did not take the condition code byte");
	a_remainder: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_PREM) & !REQ_I.partial & !REQ_I.stk_fault) |=>
		(STATUS_O[`FSW_B_C0] == $past(REQ_I.quot[2])) && !STATUS_O[`FSW_B_C2])
		else $error("remainder quotient bits misplaced");

	// The checks below tie code, flag, move and top-field updates to the request fields or inputs they came with.
	a_round_up: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_ARITH) & !REQ_I.stk_fault) |=>
		(STATUS_O[`FSW_B_C1] == $past(REQ_I.roundup)))
		else $error("arithmetic code 1 does not show the rounding direction");

	a_range_flag: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_TRIG)) |=>
		(STATUS_O[`FSW_B_C2] == $past(REQ_I.partial)))
		else $error("trig code 2 does not show the operand range");

	a_trig_round: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_TRIG) & !REQ_I.stk_fault) |=>
		(STATUS_O[`FSW_B_C1] == $past(REQ_I.roundup)))
		else $error("trig code 1 does not show the rounding direction");

	a_move_c1: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_MOVE)) |=>
		(STATUS_O[`FSW_B_C1] == $past(REQ_I.stk_fault & REQ_I.stk_over)))
		else $error("move class code 1 not cleared without an overflow fault");

	a_core_c1: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_CMPI)) |=>
		(STATUS_O[`FSW_B_C1] == $past(REQ_I.stk_fault & REQ_I.stk_over)))
		else $error("core-flag compare code 1 shows more than a stack fault");

	a_less_codes: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_CMP) & REQ_I.cmp_lt & !REQ_I.cmp_eq & !REQ_I.cmp_un &
		!REQ_I.stk_fault) |=> (STATUS_O[`FSW_B_C0] & !STATUS_O[`FSW_B_C1] &
		!STATUS_O[`FSW_B_C2] & !STATUS_O[`FSW_B_C3]))
		else $error("less-than compare codes wrong");

	a_fault_kept: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & REQ_I.exc[0] & !REQ_I.stk_fault & sf & !clr & !ld_img) |=>
		STATUS_O[`FSW_B_SF])
		else $error("invalid operand without stack fault dropped the stack fault flag");

	a_cmov_zero: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_CMOV) & (REQ_I.cmov_sel[1:0] == 2'h1)) |=>
		(CMOV_TAKE_O == $past(CORE_FLAGS_O[`FSW_B_ZF] ^ REQ_I.cmov_sel[2])))
		else $error("conditional move ignored the zero flag");

	a_cmov_carry: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_CMOV) & (REQ_I.cmov_sel[1:0] == 2'h0)) |=>
		(CMOV_TAKE_O == $past(CORE_FLAGS_O[`FSW_B_CF] ^ REQ_I.cmov_sel[2])))
		else $error("conditional move ignored the carry flag");

	a_cmov_idle: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(CE_I & !REQ_I.valid) |=> !CMOV_TAKE_O)
		else $error("conditional move taken without a request");

	a_examine_codes: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_EXAM) & !REQ_I.stk_fault) |=>
		(STATUS_O[`FSW_B_C1] == $past(REQ_I.sign)) && ({STATUS_O[`FSW_B_C3],
		STATUS_O[`FSW_B_C2], STATUS_O[`FSW_B_C0]} == $past(REQ_I.oper_class)))
		else $error("examine codes do not show sign and class");

	a_partial_c2: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		(go & (REQ_I.cls == CLS_PREM) & REQ_I.partial) |=> STATUS_O[`FSW_B_C2])
		else $error("incomplete reduction did not set code 2");

	a_image_sf: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		ld_img |=> (STATUS_O[`FSW_B_SF] == $past(IMAGE_I[`FSW_B_SF])) &&
		(STATUS_O[10:8] == $past(IMAGE_I[10:8])))
		else $error("image load did not overwrite stack fault and low codes");

	a_top_field: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		CE_I |=> (STATUS_O[13:11] == $past(TOP_I)))
		else $error("top pointer field does not follow the top input");
endmodule : fsw_flags

/* pkg/fsw_map.svh */
// Bit positions and reset values of the floating-point status word logic.
`ifndef FSW_MAP_SVH
`define FSW_MAP_SVH
`define FSW_B_SF 6
`define FSW_B_ES 7
`define FSW_B_C0 8
`define FSW_B_C1 9
`define FSW_B_C2 10
`define FSW_B_TOP 11
`define FSW_B_C3 14
`define FSW_B_BSY 15
`define FSW_B_CF 0
`define FSW_B_PF 2
`define FSW_B_ZF 6
`define FSW_RST_FLAGS 6'h00
`define FSW_RST_CC 4'h0
`define FSW_RST_WORD 16'h0000
`define FSW_RST_CORE 8'h00
`endif

/* pkg/fsw_pkg.sv */
// Types shared by the floating-point status word logic.
package fsw_pkg;
	typedef enum logic [3:0] {
		CLS_UNDEF,
		CLS_CMP,
		CLS_CMPI,
		CLS_ARITH,
		CLS_TRIG,
		CLS_MOVE,
		CLS_EXAM,
		CLS_PREM,
		CLS_IMAGE,
		CLS_CLEX,
		CLS_INIT,
		CLS_STSW,
		CLS_FLAGS_FROM_ACCUM_INSTR,
		CLS_CMOV
	} fsw_cls_t;
	typedef struct packed {
		logic valid;
		fsw_cls_t cls;
		logic [5:0] exc;
		logic stk_fault;
		logic stk_over;
		logic roundup;
		logic cmp_lt;
		logic cmp_eq;
		logic cmp_un;
		logic partial;
		logic [2:0] quot;
		logic sign;
		logic [2:0] oper_class;
		logic [2:0] cmov_sel;
	} fsw_req_t;
endpackage : fsw_pkg

/* test/fsw_core.sv */
// Core-side model that issues floating-point instructions to the flag logic.
`timescale 1ns/1ps
module fsw_core
	import fsw_pkg::*;
(
	output fsw_req_t req_o
);
	fsw_req_t last = '0;
	initial
		req_o = '0;
	// An idle port shows the inverse of the last request, so stale fields never pass as current.
	task issue(input fsw_req_t r);
		fsw_req_t t;
		if (r.valid)
			last = r;
		t = r.valid ? r : ~last;
		t.valid = r.valid;
		req_o = t;
	endtask : issue
endmodule : fsw_core

/* test/fsw_flags_bench.sv */
// Self-checking bench for the status word flag logic.
`timescale 1ns/1ps
module fsw_flags_bench;
	import fsw_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic [5:0] mask = 6'h00;
	logic [2:0] top = 3'h0;
	logic [15:0] img = 16'h0000;
	fsw_req_t req;
	logic [15:0] status, accum, eacc;
	logic exc_req, take, esf, esum, etake;
	logic [7:0] core, ecore;
	logic [5:0] ef;
	logic [3:0] ecc;
	logic [2:0] etop;
	int fails = 0;
	int checks = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	fsw_core u_core (.req_o(req));
	fsw_flags u_dut (.CLK_SYS_I(clk), .SRST_I(srst), .CE_I(ce), .REQ_I(req), .CW_MASK_I(mask),
		.TOP_I(top), .IMAGE_I(img), .STATUS_O(status), .EXC_REQ_O(exc_req), .ACCUM_O(accum),
		.CORE_FLAGS_O(core), .CMOV_TAKE_O(take));
	task conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	// The whole run needs about 3040 cycles; the ceiling leaves ample margin.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			fails++;
			conclude();
		end
	end
	function logic [15:0] word();
		return {esum, ecc[3], etop, ecc[2:0], esum, esf, ef};
	endfunction : word
	function logic cond(input logic [2:0] s);
		logic [3:0] v;
		v = {ecore[2], ecore[6] | ecore[0], ecore[6], ecore[0]};
		return v[s[1:0]] ^ s[2];
	endfunction : cond
	function fsw_req_t rq(input int c);
		fsw_req_t r;
		int k;
		r = fsw_req_t'(28'($urandom));
		k = $urandom_range(3, 0);
		r.valid = 1'b1;
		r.cls = fsw_cls_t'(c[3:0]);
		{r.cmp_un, r.cmp_eq, r.cmp_lt} = (k == 3) ? 3'h0 : 3'h1 << k;
		// Undefined, clearing and transfer instructions carry no exceptions.
		if (c == 0 || c > 7)
		begin
			r.exc = 6'h00;
			r.stk_fault = 1'b0;
		end
		return r;
	endfunction : rq
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task predict(input fsw_req_t r);
		if (!ce)
			return;
		etake = 1'b0;
		if (r.valid)
		begin
			ef = ef | r.exc | {5'h00, r.stk_fault};
			esf = esf | r.stk_fault;
			case (r.cls)
			CLS_CMP: ecc = {r.cmp_eq | r.cmp_un, r.cmp_un, 1'b0, r.cmp_lt | r.cmp_un};
			CLS_CMPI: {ecore[6], ecore[2], ecore[0], ecc[1]} =
				{r.cmp_eq | r.cmp_un, r.cmp_un, r.cmp_lt | r.cmp_un, 1'b0};
			CLS_ARITH: ecc[1] = r.roundup;
			CLS_TRIG: ecc[2:1] = {r.partial, r.roundup};
			CLS_MOVE: ecc[1] = 1'b0;
			CLS_EXAM: ecc = {r.oper_class[2:1], r.sign, r.oper_class[0]};
			CLS_PREM: {ecc[2], ecc[0], ecc[3], ecc[1]} =
				r.partial ? {1'b1, ecc[0], ecc[3], ecc[1]} : {1'b0, r.quot};
			CLS_IMAGE: {esf, ef, ecc} = {img[6], img[5:0], img[14], img[10:8]};
			CLS_CLEX: {esf, ef} = 7'h00;
			CLS_INIT: {esf, ef, ecc} = 11'h000;
			CLS_STSW: eacc = word();
			CLS_FLAGS_FROM_ACCUM_INSTR: ecore = eacc[15:8];
			CLS_CMOV: etake = cond(r.cmov_sel);
			default: ;
			endcase
			if (r.stk_fault && r.cls != CLS_IMAGE)
				ecc[1] = r.stk_over;
		end
		etop = top;
		esum = |(ef & ~mask);
	endtask : predict
	task cyc(input fsw_req_t r, input logic c, input logic [5:0] m);
		@(negedge clk);
		chk("status", word(), status);
		chk("exc_req", {15'h0000, esum}, {15'h0000, exc_req});
		chk("accum", eacc, accum);
		chk("core_flags", {8'h00, ecore}, {8'h00, core});
		chk("cmov_take", {15'h0000, etake}, {15'h0000, take});
		u_core.issue(r);
		ce = c;
		mask = m;
		top = 3'($urandom);
		img = 16'($urandom);
		predict(r);
	endtask : cyc
	initial
	begin
		fsw_req_t r;
		void'($urandom(32'h35234efe));
		{ef, esf, esum, etake, ecc, etop, eacc, ecore} = '0;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		for (int c = 0; c < 14; c++)
			cyc(rq(c), 1'b1, 6'h3f);
		cyc(rq(10), 1'b1, 6'h3f);
		r = rq(3);
		{r.exc, r.stk_fault, r.roundup} = {6'h20, 1'b0, 1'b1};
		cyc(r, 1'b1, 6'h20);
		cyc(r, 1'b1, 6'h00);
		{r.exc, r.stk_fault, r.stk_over} = {6'h00, 1'b1, 1'b1};
		cyc(r, 1'b1, 6'h00);
		{r.exc, r.stk_fault} = {6'h01, 1'b0};
		cyc(r, 1'b0, 6'h00);
		cyc(r, 1'b1, 6'h00);
		cyc(rq(11), 1'b1, 6'h00);
		cyc(rq(12), 1'b1, 6'h00);
		cyc(rq(13), 1'b1, 6'h00);
		cyc(rq(9), 1'b1, 6'h00);
		$display("test directed done");
		repeat (3000)
		begin
			r = rq($urandom_range(13, 0));
			r.valid = $urandom_range(5, 0) != 0;
			cyc(r, $urandom_range(7, 0) != 0, 6'($urandom));
		end
		r.valid = 1'b0;
		cyc(r, 1'b1, 6'h00);
		$display("test random done");
		conclude();
	end
endmodule : fsw_flags_bench
